//--- gpecl_port.sv
// Pin enable, commit mask and key lock of one GPIO port, with an AXI4-Lite slave.
// Assumes a single clock, a synchronous active-low reset and pad levels from outside.
// How it works
// - Cleared enable bit: pin undriven, input blocked.
// - Enables reset to zero except debug pins.
// - Writing the key unlocks the commit mask.
// - Writing any other value relocks.
// - Any commit mask write relocks.
// - Lock reads status, one locked; reset locked.
// - Locked commit mask writes are ignored.
// - Select bits change only where mask set.
// - Non-debug mask bits are fixed at one.
// - Mask resets all ones, debug bits zero.
// - Read-only identification byte, upper bits zero.
module gpecl_port #(
  parameter logic [7:0] DEBUG_PINS = gpecl_pkg::PORT_PLAIN_DEBUG_PINS,
  parameter logic [7:0] IDENT_FIELD_FOUR = 8'h3C // Arbitrary value, no maker code.
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [gpecl_pkg::ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [gpecl_pkg::ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire gpecl_pkg::gpecl_src_s funcSrc,
  input wire logic [7:0] padIn,
  output gpecl_pkg::gpecl_pad_s padDrive,
  output logic [7:0] pinInput,
  output logic [7:0] digitalFunctionOn,
  output logic [7:0] altFunctionSelect,
  output logic commitLocked
);
  import gpecl_pkg::*;

  // Protected pins leave reset enabled and selected, but not committable.
  localparam logic [7:0] ENABLE_RESET = ENABLE_RESET_PLAIN | DEBUG_PINS;
  localparam logic [7:0] COMMIT_RESET = COMMIT_RESET_PLAIN & ~DEBUG_PINS;
  localparam logic [7:0] SELECT_RESET = ENABLE_RESET_PLAIN | DEBUG_PINS;

  function automatic gpecl_sel_e decodeSel(input logic [ADDR_WIDTH-1:0] addr);
    logic [11:0] word;
    word = {addr[11:2], 2'b00};
    case (word)
      OFS_ALT_FUNCTION_SELECT: decodeSel = SEL_ALT_SELECT;
      OFS_PIN_DIGITAL_ENABLE: decodeSel = SEL_ENABLE;
      OFS_COMMIT_KEY_LOCK: decodeSel = SEL_LOCK;
      OFS_ALT_FUNCTION_COMMIT_MASK: decodeSel = SEL_COMMIT;
      OFS_IDENT_BYTE_FOUR: decodeSel = SEL_IDENT;
      default: decodeSel = SEL_NONE;
    endcase
  endfunction

  logic [7:0] enable_ff;
  logic [7:0] altSelect_ff;
  logic [7:0] commitMask_ff;
  logic locked_ff;
  logic awHeld_ff;
  logic wHeld_ff;
  logic [ADDR_WIDTH-1:0] awAddr_ff;
  logic [31:0] wData_ff;
  logic [3:0] wStrb_ff;
  logic awReady_ff;
  logic wReady_ff;
  logic bValid_ff;
  logic [1:0] bResp_ff;
  logic arReady_ff;
  logic rValid_ff;
  logic [31:0] rData_ff;
  logic [1:0] rResp_ff;
  logic [7:0] padSync1_ff;
  logic [7:0] padSync2_ff;
  logic [7:0] pinInput_ff;
  gpecl_pad_s padDrive_ff;

  logic awTake;
  logic wTake;
  logic arTake;
  logic doWrite;
  logic [ADDR_WIDTH-1:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  gpecl_sel_e wrSel;
  gpecl_sel_e rdSel;
  logic lowLane;
  logic keyMatch;
  logic [31:0] rdValue;

  assign awTake = s_axi_awvalid & awReady_ff;
  assign wTake = s_axi_wvalid & wReady_ff;
  assign arTake = s_axi_arvalid & arReady_ff;
  assign doWrite = (awHeld_ff | awTake) & (wHeld_ff | wTake) & ~bValid_ff;
  assign wrAddr = awTake ? s_axi_awaddr : awAddr_ff;
  assign wrData = wTake ? s_axi_wdata : wData_ff;
  assign wrStrb = wTake ? s_axi_wstrb : wStrb_ff;
  assign wrSel = decodeSel(wrAddr);
  assign rdSel = decodeSel(s_axi_araddr);
  assign lowLane = wrStrb[0];
  // A partial write of the lock word can never match the key, so it relocks.
  assign keyMatch = (wrStrb == 4'hF) && (wrData == UNLOCK_KEY);

  // Write address and data are taken in either order and held until both are here.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      awHeld_ff <= 1'b0;
      awAddr_ff <= '0;
      awReady_ff <= 1'b0;
    end else begin
      if (awTake) begin
        awAddr_ff <= s_axi_awaddr;
      end
      if (doWrite) begin
        awHeld_ff <= 1'b0;
      end else if (awTake) begin
        awHeld_ff <= 1'b1;
      end
      if (awTake) begin
        awReady_ff <= 1'b0;
      end else if (!awHeld_ff && !bValid_ff && !doWrite) begin
        awReady_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wHeld_ff <= 1'b0;
      wData_ff <= '0;
      wStrb_ff <= '0;
      wReady_ff <= 1'b0;
    end else begin
      if (wTake) begin
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      if (doWrite) begin
        wHeld_ff <= 1'b0;
      end else if (wTake) begin
        wHeld_ff <= 1'b1;
      end
      if (wTake) begin
        wReady_ff <= 1'b0;
      end else if (!wHeld_ff && !bValid_ff && !doWrite) begin
        wReady_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bValid_ff <= 1'b0;
      bResp_ff <= RESP_OKAY;
    end else if (doWrite) begin
      bValid_ff <= 1'b1;
      bResp_ff <= (wrSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (bValid_ff && s_axi_bready) begin
      bValid_ff <= 1'b0;
    end
  end

  // Each instance holds its own copy of this state; nothing is shared between ports.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enable_ff <= ENABLE_RESET;
    end else if (doWrite && wrSel == SEL_ENABLE && lowLane) begin
      enable_ff <= wrData[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      locked_ff <= LOCK_RESET;
    end else if (doWrite && wrSel == SEL_LOCK) begin
      locked_ff <= ~keyMatch;
    end else if (doWrite && wrSel == SEL_COMMIT) begin
      locked_ff <= 1'b1;
    end
  end

  // Only the debug pins are writable; the rest stay at one so they can always be committed.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      commitMask_ff <= COMMIT_RESET;
    end else if (doWrite && wrSel == SEL_COMMIT && !locked_ff && lowLane) begin
      commitMask_ff <= (wrData[7:0] & DEBUG_PINS) | ~DEBUG_PINS;
    end
  end

  // Software is expected to unlock and set the mask before touching the select bits.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      altSelect_ff <= SELECT_RESET;
    end else if (doWrite && wrSel == SEL_ALT_SELECT && lowLane) begin
      altSelect_ff <= (wrData[7:0] & commitMask_ff) | (altSelect_ff & ~commitMask_ff);
    end
  end

  always_comb begin
    rdValue = 32'h0000_0000;
    case (rdSel)
      SEL_ALT_SELECT: rdValue = {24'h00_0000, altSelect_ff};
      SEL_ENABLE: rdValue = {24'h00_0000, enable_ff};
      SEL_LOCK: rdValue = locked_ff ? LOCK_READ_LOCKED : LOCK_READ_UNLOCKED;
      SEL_COMMIT: rdValue = {24'h00_0000, commitMask_ff};
      SEL_IDENT: rdValue = {24'h00_0000, IDENT_FIELD_FOUR};
      default: rdValue = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      arReady_ff <= 1'b0;
      rValid_ff <= 1'b0;
      rData_ff <= '0;
      rResp_ff <= RESP_OKAY;
    end else begin
      if (arTake) begin
        arReady_ff <= 1'b0;
        rValid_ff <= 1'b1;
        rData_ff <= rdValue;
        rResp_ff <= (rdSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else begin
        if (rValid_ff && s_axi_rready) begin
          rValid_ff <= 1'b0;
        end
        if (!rValid_ff && !arReady_ff) begin
          arReady_ff <= 1'b1;
        end
      end
    end
  end

  // Pad levels are asynchronous, so they pass two flops before the enable gate.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      padSync1_ff <= '0;
      padSync2_ff <= '0;
    end else begin
      padSync1_ff <= padIn;
      padSync2_ff <= padSync1_ff;
    end
  end

  // Registered pad drive costs one cycle of latency but keeps the pad ring glitch free.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      padDrive_ff <= '0;
      pinInput_ff <= '0;
    end else begin
      padDrive_ff.outEnable <= enable_ff &
        ((altSelect_ff & funcSrc.altDir) | (~altSelect_ff & funcSrc.coreDir));
      padDrive_ff.outValue <= enable_ff &
        ((altSelect_ff & funcSrc.altOut) | (~altSelect_ff & funcSrc.coreOut));
      pinInput_ff <= enable_ff & padSync2_ff;
    end
  end

  assign s_axi_awready = awReady_ff;
  assign s_axi_wready = wReady_ff;
  assign s_axi_bvalid = bValid_ff;
  assign s_axi_bresp = bResp_ff;
  assign s_axi_arready = arReady_ff;
  assign s_axi_rvalid = rValid_ff;
  assign s_axi_rdata = rData_ff;
  assign s_axi_rresp = rResp_ff;
  assign padDrive = padDrive_ff;
  assign pinInput = pinInput_ff;
  assign digitalFunctionOn = enable_ff;
  assign altFunctionSelect = altSelect_ff;
  assign commitLocked = locked_ff;

  chk_pin_undriven: assert property (@(posedge clk) disable iff (!rst_n)
    ((padDrive_ff.outEnable | pinInput_ff) & ~$past(enable_ff)) == 8'h00)
    else $error("Disabled pin is driven or passes input.");

  chk_reset_values: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(rst_n) |-> (enable_ff == ENABLE_RESET) && locked_ff)
    else $error("Enable or lock wrong after reset.");

  chk_key_unlock: assert property (@(posedge clk) disable iff (!rst_n)
    doWrite && wrSel == SEL_LOCK && keyMatch |=> !locked_ff ##1 (locked_ff == $past(locked_ff)
    || $past(doWrite)))
    else $error("Key write did not unlock.");

  chk_other_relock: assert property (@(posedge clk) disable iff (!rst_n)
    doWrite && wrSel == SEL_LOCK && !keyMatch |=> locked_ff)
    else $error("Non-key write did not lock.");

  chk_commit_relock: assert property (@(posedge clk) disable iff (!rst_n)
    doWrite && wrSel == SEL_COMMIT |=> locked_ff)
    else $error("Commit mask write left block unlocked.");

  chk_lock_read: assert property (@(posedge clk) disable iff (!rst_n)
    arTake && rdSel == SEL_LOCK |=> rValid_ff && rData_ff == {31'h0000_0000, $past(locked_ff)})
    else $error("Lock read does not show status.");

  chk_locked_ignore: assert property (@(posedge clk) disable iff (!rst_n)
    doWrite && wrSel == SEL_COMMIT && locked_ff |=> commitMask_ff == $past(commitMask_ff))
    else $error("Locked commit mask changed.");

  chk_select_mask: assert property (@(posedge clk) disable iff (!rst_n)
    doWrite && wrSel == SEL_ALT_SELECT && lowLane |=>
      ((altSelect_ff ^ $past(altSelect_ff)) & ~$past(commitMask_ff)) == 8'h00 &&
      ((altSelect_ff ^ $past(wrData[7:0])) & $past(commitMask_ff)) == 8'h00)
    else $error("Select bits ignored the commit mask.");

  chk_mask_hardwired: assert property (@(posedge clk) disable iff (!rst_n)
    (commitMask_ff & ~DEBUG_PINS) == ~DEBUG_PINS)
    else $error("Hardwired commit bit cleared.");

  chk_mask_reset: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(rst_n) |-> commitMask_ff == COMMIT_RESET)
    else $error("Commit mask wrong after reset.");

  chk_ident_read: assert property (@(posedge clk) disable iff (!rst_n)
    arTake && rdSel == SEL_IDENT |=> rData_ff == {24'h00_0000, IDENT_FIELD_FOUR})
    else $error("Identification byte read wrong.");

  chk_value_gated: assert property (@(posedge clk) disable iff (!rst_n)
    (padDrive_ff.outValue & ~$past(enable_ff)) == 8'h00)
    else $error("Disabled pin drives a value.");

  chk_mask_write: assert property (@(posedge clk) disable iff (!rst_n)
    doWrite && wrSel == SEL_COMMIT && !locked_ff && lowLane |=>
      commitMask_ff == (($past(wrData[7:0]) & DEBUG_PINS) | ~DEBUG_PINS))
    else $error("Unlocked commit mask write not taken.");

  chk_key_partial: assert property (@(posedge clk) disable iff (!rst_n)
    doWrite && wrSel == SEL_LOCK && wrStrb != 4'hF |=> locked_ff)
    else $error("Partial key write did not lock.");

endmodule

//--- gpecl_pkg.sv
// Constants and types for the pin enable, commit and lock block of one GPIO port.
// Assumes a 32-bit AXI4-Lite master and eight pins per port.
package gpecl_pkg;

  localparam int PIN_COUNT = 8;
  localparam int ADDR_WIDTH = 12;

  // Register byte offsets inside the port window.
  localparam logic [11:0] OFS_ALT_FUNCTION_SELECT = 12'h420;
  localparam logic [11:0] OFS_PIN_DIGITAL_ENABLE = 12'h51C;
  localparam logic [11:0] OFS_COMMIT_KEY_LOCK = 12'h520;
  localparam logic [11:0] OFS_ALT_FUNCTION_COMMIT_MASK = 12'h524;
  localparam logic [11:0] OFS_IDENT_BYTE_FOUR = 12'hFD0;

  // Debug-port pin sets of the two protected ports, and of an ordinary port.
  localparam logic [7:0] PORT_B_DEBUG_PINS = 8'h80;
  localparam logic [7:0] PORT_C_DEBUG_PINS = 8'h0F;
  localparam logic [7:0] PORT_PLAIN_DEBUG_PINS = 8'h00;

  // Reset values of an ordinary port; protected pins flip them.
  localparam logic [7:0] ENABLE_RESET_PLAIN = 8'h00;
  localparam logic [7:0] COMMIT_RESET_PLAIN = 8'hFF;

  // Lock key and lock status as read back.
  localparam logic [31:0] UNLOCK_KEY = 32'h1ACC_E551;
  localparam logic [31:0] LOCK_READ_LOCKED = 32'h0000_0001;
  localparam logic [31:0] LOCK_READ_UNLOCKED = 32'h0000_0000;
  localparam logic LOCK_RESET = 1'b1;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_ALT_SELECT,
    SEL_ENABLE,
    SEL_LOCK,
    SEL_COMMIT,
    SEL_IDENT
  } gpecl_sel_e;

  // Drive seen by the pad ring for all pins of the port.
  typedef struct packed {
    logic [7:0] outValue;
    logic [7:0] outEnable;
  } gpecl_pad_s;

  // Function sources that compete for the pins.
  typedef struct packed {
    logic [7:0] coreOut;
    logic [7:0] coreDir;
    logic [7:0] altOut;
    logic [7:0] altDir;
  } gpecl_src_s;

endpackage

//--- tb_gpio_pin_enable_commit_lock.sv
// Self-checking bench for two port instances of the pin enable, commit and lock block.
// Assumes the AXI4-Lite slave of the package and pin paths that settle within four cycles.
module tb_gpio_pin_enable_commit_lock;
  timeunit 1ns;
  timeprecision 1ps;
  import gpecl_pkg::*;
  localparam logic [7:0] ID_FOUR = 8'h5A; // Arbitrary identification value.
  logic clk, rst_n, bReady, rReady;
  logic [11:0] awAddr, arAddr;
  logic [31:0] wData, rd, d;
  logic [3:0] wStrb, st;
  logic [1:0] rsp;
  logic awValid [2], wValid [2], arValid [2];
  logic awRdy [2], wRdy [2], bValid [2], arRdy [2], rValid [2], locked [2];
  logic [1:0] bResp [2], rResp [2];
  logic [31:0] rData [2];
  gpecl_src_s funcSrc;
  gpecl_pad_s pad [2];
  logic [7:0] padIn, m;
  logic [7:0] pinIn [2], denOut [2], selOut [2];
  logic [7:0] dbg [2], msk [2], sel [2], en [2];
  int n_mismatch, n_checks, seed, p;

  for (genvar i = 0; i < 2; i++) begin : g_port
    gpecl_port #(.DEBUG_PINS(i == 0 ? 8'h80 : 8'h0F), .IDENT_FIELD_FOUR(ID_FOUR)) gpecl_port_inst (
      .clk(clk), .rst_n(rst_n), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid[i]),
      .s_axi_awready(awRdy[i]), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
      .s_axi_wvalid(wValid[i]), .s_axi_wready(wRdy[i]), .s_axi_bresp(bResp[i]),
      .s_axi_bvalid(bValid[i]), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
      .s_axi_arvalid(arValid[i]), .s_axi_arready(arRdy[i]), .s_axi_rdata(rData[i]),
      .s_axi_rresp(rResp[i]), .s_axi_rvalid(rValid[i]), .s_axi_rready(rReady),
      .funcSrc(funcSrc), .padIn(padIn), .padDrive(pad[i]), .pinInput(pinIn[i]),
      .digitalFunctionOn(denOut[i]), .altFunctionSelect(selOut[i]), .commitLocked(locked[i]));
  end

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic finish_test();
    if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen 0x%08h expected 0x%08h", $time, seen, exp);
    end
  endtask

  // A slave that never answers must not hang the run.
  task automatic tmo(input int k);
    if (k >= 200) begin
      n_mismatch++;
      finish_test();
    end
  endtask

  task automatic wr(input int q, input logic [11:0] a, input logic [31:0] v, input logic [3:0] s,
                    input logic [1:0] er);
    int k;
    awAddr <= a;
    wData <= v;
    wStrb <= s;
    awValid[q] <= 1'b1;
    wValid[q] <= 1'b1;
    bReady <= 1'b1;
    for (k = 0; k < 200; k++) begin
      @(posedge clk);
      if (awRdy[q] === 1'b1) awValid[q] <= 1'b0;
      if (wRdy[q] === 1'b1) wValid[q] <= 1'b0;
      if (bValid[q] === 1'b1) break;
    end
    tmo(k);
    rsp = bResp[q];
    chk(32'(rsp), 32'(er));
  endtask

  task automatic rc(input int q, input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    int k;
    arAddr <= a;
    arValid[q] <= 1'b1;
    rReady <= 1'b1;
    for (k = 0; k < 200; k++) begin
      @(posedge clk);
      if (arRdy[q] === 1'b1) arValid[q] <= 1'b0;
      if (rValid[q] === 1'b1) break;
    end
    tmo(k);
    rd = rData[q];
    rsp = rResp[q];
    chk(rd, exp);
    chk(32'(rsp), 32'(er));
  endtask

  task automatic rstChk();
    for (int q = 0; q < 2; q++) begin
      en[q] = dbg[q];
      sel[q] = dbg[q];
      msk[q] = ~dbg[q];
      rc(q, OFS_PIN_DIGITAL_ENABLE, {24'h0, dbg[q]}, RESP_OKAY);
      rc(q, OFS_COMMIT_KEY_LOCK, 32'h0000_0001, RESP_OKAY);
      rc(q, OFS_ALT_FUNCTION_COMMIT_MASK, {24'h0, ~dbg[q]}, RESP_OKAY);
      rc(q, OFS_ALT_FUNCTION_SELECT, {24'h0, dbg[q]}, RESP_OKAY);
      rc(q, OFS_IDENT_BYTE_FOUR, {24'h0, ID_FOUR}, RESP_OKAY);
    end
  endtask

  // The select bit picks the source and the enable bit gates it, so a disabled pin is quiet.
  function automatic logic [7:0] padExp(input int q, input logic [7:0] alt,
                                        input logic [7:0] core);
    return en[q] & ((sel[q] & alt) | (~sel[q] & core));
  endfunction

  // The input path has a two-flop synchroniser, so four edges are waited before looking.
  task automatic pinChk(input int q);
    repeat (4) @(posedge clk);
    chk(32'(denOut[q]), 32'(en[q]));
    chk(32'(pinIn[q]), 32'(en[q] & padIn));
    chk(32'(pad[q].outEnable), 32'(padExp(q, funcSrc.altDir, funcSrc.coreDir)));
    chk(32'(pad[q].outValue), 32'(padExp(q, funcSrc.altOut, funcSrc.coreOut)));
    chk(32'(selOut[q]), 32'(sel[q]));
  endtask

  initial begin
    seed = 34278;
    n_mismatch = 0;
    n_checks = 0;
    rst_n = 1'b0;
    bReady = 1'b0;
    rReady = 1'b0;
    awAddr = '0;
    arAddr = '0;
    wData = '0;
    wStrb = '0;
    padIn = '0;
    funcSrc = '0;
    for (int q = 0; q < 2; q++) begin
      awValid[q] = 1'b0;
      wValid[q] = 1'b0;
      arValid[q] = 1'b0;
    end
    dbg[0] = 8'h80;
    dbg[1] = 8'h0F;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rstChk();
    rc(0, 12'h000, 32'h0000_0000, RESP_SLVERR);
    wr(1, 12'h004, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
    wr(0, OFS_IDENT_BYTE_FOUR, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
    rc(0, OFS_IDENT_BYTE_FOUR, {24'h0, ID_FOUR}, RESP_OKAY);
    wr(0, OFS_ALT_FUNCTION_COMMIT_MASK, 32'h0000_00FF, 4'hF, RESP_OKAY);
    rc(0, OFS_ALT_FUNCTION_COMMIT_MASK, 32'h0000_007F, RESP_OKAY);
    wr(0, OFS_COMMIT_KEY_LOCK, 32'h1ACC_E551, 4'hF, RESP_OKAY);
    chk(32'(locked[0]), 32'h0000_0000);
    rc(0, OFS_COMMIT_KEY_LOCK, 32'h0000_0000, RESP_OKAY);
    rc(1, OFS_COMMIT_KEY_LOCK, 32'h0000_0001, RESP_OKAY);
    wr(0, OFS_COMMIT_KEY_LOCK, 32'h1ACC_E550, 4'hF, RESP_OKAY);
    rc(0, OFS_COMMIT_KEY_LOCK, 32'h0000_0001, RESP_OKAY);
    // A key written with a partial strobe is not the key, so it must relock.
    wr(0, OFS_COMMIT_KEY_LOCK, 32'h1ACC_E551, 4'hF, RESP_OKAY);
    wr(0, OFS_COMMIT_KEY_LOCK, 32'h1ACC_E551, 4'h7, RESP_OKAY);
    rc(0, OFS_COMMIT_KEY_LOCK, 32'h0000_0001, RESP_OKAY);
    wr(0, OFS_COMMIT_KEY_LOCK, 32'h1ACC_E551, 4'hF, RESP_OKAY);
    wr(0, OFS_ALT_FUNCTION_COMMIT_MASK, 32'h0000_0080, 4'hF, RESP_OKAY);
    rc(0, OFS_COMMIT_KEY_LOCK, 32'h0000_0001, RESP_OKAY);
    wr(0, OFS_ALT_FUNCTION_COMMIT_MASK, 32'h0000_0000, 4'hF, RESP_OKAY);
    rc(0, OFS_ALT_FUNCTION_COMMIT_MASK, 32'h0000_00FF, RESP_OKAY);
    msk[0] = 8'hFF;
    wr(1, OFS_COMMIT_KEY_LOCK, 32'h1ACC_E551, 4'hF, RESP_OKAY);
    wr(1, OFS_ALT_FUNCTION_COMMIT_MASK, 32'h0000_0000, 4'hF, RESP_OKAY);
    rc(1, OFS_ALT_FUNCTION_COMMIT_MASK, 32'h0000_00F0, RESP_OKAY);
    msk[1] = 8'hF0;
    for (int i = 0; i < 40; i++) begin
      p = i % 2;
      if (($random(seed) & 3) == 0) begin
        m = 8'($random(seed));
        wr(p, OFS_COMMIT_KEY_LOCK, 32'h1ACC_E551, 4'hF, RESP_OKAY);
        wr(p, OFS_ALT_FUNCTION_COMMIT_MASK, {24'h0, m}, 4'hF, RESP_OKAY);
        msk[p] = m | ~dbg[p];
      end
      d = $random(seed);
      wr(p, OFS_ALT_FUNCTION_SELECT, d, 4'hF, RESP_OKAY);
      sel[p] = (sel[p] & ~msk[p]) | (d[7:0] & msk[p]);
      funcSrc <= $random(seed);
      padIn <= 8'($random(seed));
      d = $random(seed);
      st = 4'($random(seed));
      wr(p, OFS_PIN_DIGITAL_ENABLE, d, st, RESP_OKAY);
      if (st[0]) en[p] = d[7:0];
      rc(p, OFS_PIN_DIGITAL_ENABLE, {24'h0, en[p]}, RESP_OKAY);
      rc(p, OFS_ALT_FUNCTION_COMMIT_MASK, {24'h0, msk[p]}, RESP_OKAY);
      pinChk(p);
    end
    // A second reset in mid-run must bring back every reset value, the lock included.
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rstChk();
    finish_test();
  end
endmodule
